// [hdl/dcp_map.svh]
`ifndef DCP_MAP_SVH
`define DCP_MAP_SVH

// serial register load address of the charge enable map
`define DCP_CHARGE_EN_ADDR 8'hd0
`define DCP_CHARGE_EN_RESET 8'h00
// port 1 sits at bit 1
`define DCP_CHARGE_EN_FIRST_BIT 1
`define DCP_NUM_PORTS 3

`endif

// [hdl/dcp_pkg.sv]
package dcp_pkg;

    // serial register write from the configuration loader
    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [7:0] data;
    } dcp_reg_wr_t;

    // per-port ownership of the power enable
    typedef enum logic [2:0] {
        DCP_ST_CONFIG = 3'b001,
        DCP_ST_CHARGE = 3'b010,
        DCP_ST_HUB = 3'b100
    } dcp_own_t;

endpackage

// [hdl/dcp_charge_port_power.sv]
`timescale 1ns/1ns
`default_nettype none
`include "dcp_map.svh"

// Function
// [RULE1] port role frozen after initial configuration
// [RULE2] charging port answers query, else silent
// [RULE3] charging logic drives enable of charging ports
// [RULE4] assert charging port enable after configuration
// [RULE5] charge-owned overcurrent latches enable off until reset; the hub owner ignores the latch while port power feature is set
// [RULE6] enumeration hands enable back to hub
// [RULE7] port power feature selects enable owner
// [RULE8] overcurrent always negates enable
// [RULE9] enable register d0, bit 1 is port 1
// [RULE10] charging enable sets port power bit
// [RULE11] external controller writes map over serial port
// [RULE12] charging capability indicated per port
// [RULE13] enables low, latches clear before configuration
module dcp_charge_port_power
    import dcp_pkg::*;
#(
    parameter int NUM_PORTS = `DCP_NUM_PORTS
)
(
    // clock and reset
    input wire logic SYS_CLK_IN,
    input wire logic RST_B_IN,
    // serial register load
    input wire dcp_reg_wr_t REG_WR_IN,
    input wire logic CONFIG_DONE_IN,
    output logic [7:0] CHARGE_PORT_ENABLE_MAP_OUT,
    // hub state
    input wire logic [NUM_PORTS-1:0] HUB_PORT_POWER_FEATURE_IN,
    input wire logic [NUM_PORTS-1:0] HUB_PORT_POWER_ENABLE_IN,
    // charging query per port
    input wire logic [NUM_PORTS-1:0] CHARGE_QUERY_IN,
    output logic [NUM_PORTS-1:0] CHARGE_ACK_OUT,
    output logic [NUM_PORTS-1:0] CHARGE_CAPABLE_OUT,
    // port power pins
    input wire logic [NUM_PORTS-1:0] OVERCURRENT_SENSE_LOW_IN,
    output logic [NUM_PORTS-1:0] PORT_POWER_ENABLE_OUT,
    output logic [NUM_PORTS-1:0] OVERCURRENT_LATCHED_OUT
);

    logic [7:0] charge_map_q;
    logic [7:0] charge_map_d;
    logic cfg_done_q;
    logic cfg_done_d;
    logic [NUM_PORTS-1:0] ocl_q;
    logic [NUM_PORTS-1:0] ocl_d;
    logic [NUM_PORTS-1:0] pwr_q;
    logic [NUM_PORTS-1:0] pwr_d;
    logic [NUM_PORTS-1:0] ack_q;
    logic [NUM_PORTS-1:0] ack_d;
    logic [NUM_PORTS-1:0] charge_en;
    logic [NUM_PORTS-1:0] fault_now;
    logic map_wr;
    dcp_own_t own_q [NUM_PORTS];
    dcp_own_t own_d [NUM_PORTS];

    // map write accepted only before configuration ends
    function automatic logic map_write_hit(input dcp_reg_wr_t wr, input logic done);
        logic hit;
        hit = wr.valid && !done;
        hit = hit && (wr.addr == `DCP_CHARGE_EN_ADDR);
        return hit;
    endfunction

    // charge enable of one port, port 1 at bit 1
    function automatic logic map_bit(input logic [7:0] map, input int port);
        logic bit_val;
        bit_val = map[port + `DCP_CHARGE_EN_FIRST_BIT];
        return bit_val;
    endfunction

    // enable as the hub logic wants it
    function automatic logic hub_drive(input logic feature, input logic hub_en, input logic ocs_low);
        logic on;
        on = feature && hub_en;
        on = on && ocs_low;
        return on;
    endfunction

    // enable as the charging logic wants it
    function automatic logic charge_drive(input logic latched, input logic ocs_low, input logic feature);
        logic on;
        on = !latched && ocs_low;
        on = on && !feature;
        return on;
    endfunction

    // decode of map and fault pins
    always_comb
    begin
        map_wr = map_write_hit(REG_WR_IN, cfg_done_q);
        // [RULE9] [RULE12] bit 1 is port 1
        for (int i = 0; i < NUM_PORTS; i++)
        begin
            charge_en[i] = map_bit(charge_map_q, i);
            fault_now[i] = !OVERCURRENT_SENSE_LOW_IN[i];
        end
    end

    // charge enable map
    always_comb
    begin
        charge_map_d = charge_map_q;
        // [RULE1] [RULE11] writes refused once configured
        if (map_wr)
        begin
            charge_map_d = REG_WR_IN.data;
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            charge_map_q <= `DCP_CHARGE_EN_RESET;
        end
        else
        begin
            charge_map_q <= charge_map_d;
        end
    end

    // sticky end of initial configuration
    always_comb
    begin
        cfg_done_d = cfg_done_q | CONFIG_DONE_IN;
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            cfg_done_q <= 1'b0;
        end
        else
        begin
            cfg_done_q <= cfg_done_d;
        end
    end

    // per-port owner of the power enable
    always_comb
    begin
        for (int i = 0; i < NUM_PORTS; i++)
        begin
            own_d[i] = own_q[i];
            case (own_q[i])
                DCP_ST_CONFIG:
                begin
                    // [RULE13] held off until configured
                    if (cfg_done_q)
                    begin
                        own_d[i] = charge_en[i] ? DCP_ST_CHARGE : DCP_ST_HUB;
                    end
                end
                DCP_ST_CHARGE:
                begin
                    // [RULE6] [RULE7] feature set hands over to hub
                    if (HUB_PORT_POWER_FEATURE_IN[i])
                    begin
                        own_d[i] = DCP_ST_HUB;
                    end
                end
                DCP_ST_HUB:
                begin
                    // [RULE7] feature cleared returns charging ports
                    if (!HUB_PORT_POWER_FEATURE_IN[i] && charge_en[i])
                    begin
                        own_d[i] = DCP_ST_CHARGE;
                    end
                end
                default:
                begin
                    own_d[i] = DCP_ST_CONFIG;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            for (int i = 0; i < NUM_PORTS; i++)
            begin
                own_q[i] <= DCP_ST_CONFIG;
            end
        end
        else
        begin
            for (int i = 0; i < NUM_PORTS; i++)
            begin
                own_q[i] <= own_d[i];
            end
        end
    end

    // overcurrent latch, cleared only by reset
    always_comb
    begin
        ocl_d = ocl_q;
        for (int i = 0; i < NUM_PORTS; i++)
        begin
            // [RULE5] sticky overcurrent under charge control
            if (own_q[i] == DCP_ST_CHARGE && fault_now[i])
            begin
                ocl_d[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            ocl_q <= '0;
        end
        else
        begin
            ocl_q <= ocl_d;
        end
    end

    // port power enable
    always_comb
    begin
        pwr_d = '0;
        for (int i = 0; i < NUM_PORTS; i++)
        begin
            case (own_q[i])
                DCP_ST_CHARGE:
                begin
                    // [RULE3] [RULE4] [RULE10] charging logic drives enable
                    pwr_d[i] = charge_drive(ocl_q[i], OVERCURRENT_SENSE_LOW_IN[i], HUB_PORT_POWER_FEATURE_IN[i]);
                end
                DCP_ST_HUB:
                begin
                    // [RULE8] overcurrent negates hub control too
                    pwr_d[i] = hub_drive(HUB_PORT_POWER_FEATURE_IN[i], HUB_PORT_POWER_ENABLE_IN[i],
                        OVERCURRENT_SENSE_LOW_IN[i]);
                    // [RULE7] feature cleared gives charging ports back
                    if (charge_en[i] && !HUB_PORT_POWER_FEATURE_IN[i])
                    begin
                        pwr_d[i] = charge_drive(ocl_q[i], OVERCURRENT_SENSE_LOW_IN[i], 1'b0);
                    end
                end
                default:
                begin
                    // [RULE13] off until configured
                    pwr_d[i] = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            pwr_q <= '0;
        end
        else
        begin
            pwr_q <= pwr_d;
        end
    end

    // charging query answer
    always_comb
    begin
        for (int i = 0; i < NUM_PORTS; i++)
        begin
            // [RULE2] answer only on charging ports
            ack_d[i] = CHARGE_QUERY_IN[i] && cfg_done_q && charge_en[i];
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            ack_q <= '0;
        end
        else
        begin
            ack_q <= ack_d;
        end
    end

    assign CHARGE_PORT_ENABLE_MAP_OUT = charge_map_q;
    assign PORT_POWER_ENABLE_OUT = pwr_q;
    assign CHARGE_ACK_OUT = ack_q;
    assign CHARGE_CAPABLE_OUT = charge_en & {NUM_PORTS{cfg_done_q}};
    assign OVERCURRENT_LATCHED_OUT = ocl_q;

endmodule

`default_nettype wire

// [verification/dcp_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module dcp_sva
#(
    parameter int NUM_PORTS = 3
)
(
    input wire logic SYS_CLK_IN, RST_B_IN, CONFIG_DONE_IN,
    input wire logic [7:0] CHARGE_PORT_ENABLE_MAP_OUT,
    input wire logic [NUM_PORTS-1:0] HUB_PORT_POWER_FEATURE_IN, HUB_PORT_POWER_ENABLE_IN, CHARGE_QUERY_IN,
    input wire logic [NUM_PORTS-1:0] CHARGE_ACK_OUT, CHARGE_CAPABLE_OUT, OVERCURRENT_SENSE_LOW_IN,
    input wire logic [NUM_PORTS-1:0] PORT_POWER_ENABLE_OUT, OVERCURRENT_LATCHED_OUT
);
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    AST_ACK: assert property (CHARGE_ACK_OUT == ($past(CHARGE_QUERY_IN) & $past(CHARGE_CAPABLE_OUT)))
        else $error("ack wrong");
    AST_OC: assert property ((PORT_POWER_ENABLE_OUT & ~$past(OVERCURRENT_SENSE_LOW_IN)) == 0)
        else $error("enable during fault");
    AST_LATCH: assert property ((OVERCURRENT_LATCHED_OUT & PORT_POWER_ENABLE_OUT & ~$past(HUB_PORT_POWER_FEATURE_IN)) == 0)
        else $error("latched port on");
    AST_HUB: assert property ((PORT_POWER_ENABLE_OUT & $past(HUB_PORT_POWER_FEATURE_IN) & ~$past(HUB_PORT_POWER_ENABLE_IN)) == 0)
        else $error("hub owner ignored");
    AST_STD: assert property ((PORT_POWER_ENABLE_OUT & ~CHARGE_CAPABLE_OUT & ~$past(HUB_PORT_POWER_FEATURE_IN)) == 0)
        else $error("standard port on");
    AST_PRE: assert property (!$past(CONFIG_DONE_IN) |-> PORT_POWER_ENABLE_OUT == 0 && CHARGE_CAPABLE_OUT == 0)
        else $error("active before config");
    AST_ON: assert property ($rose(CONFIG_DONE_IN) |-> ##[2:5] (PORT_POWER_ENABLE_OUT == CHARGE_CAPABLE_OUT && CHARGE_CAPABLE_OUT != 0))
        else $error("charge port not on");
    AST_ROLE: assert property ($past(CONFIG_DONE_IN, 2) |-> $stable(CHARGE_PORT_ENABLE_MAP_OUT) && $stable(CHARGE_CAPABLE_OUT))
        else $error("role changed");
    cover property (OVERCURRENT_LATCHED_OUT != 0);
    cover property (CHARGE_ACK_OUT != 0);
    cover property (HUB_PORT_POWER_FEATURE_IN != 0 && PORT_POWER_ENABLE_OUT != 0);
endmodule
bind dcp_charge_port_power dcp_sva #(.NUM_PORTS(NUM_PORTS)) sva (.*);
`default_nettype wire

// [verification/dcp_dev_model.sv]
`timescale 1ns/1ns
`default_nettype none
module dcp_dev_model
(
    input wire logic [2:0] ask_in,
    input wire logic [2:0] fault_in,
    output logic [2:0] query_out,
    output logic [2:0] ocs_low_out
);
    assign query_out = ask_in;
    // sense pulled high when no fault
    assign ocs_low_out = ~fault_in;
endmodule
`default_nettype wire

// [verification/dcp_charge_port_power_bench.sv]
`timescale 1ns/1ns
`default_nettype none
module dcp_charge_port_power_bench;
    import dcp_pkg::*;
    logic clk = 0, rst_b = 0, done = 0;
    logic [2:0] feat = 0, hen = 0, ask = 0, flt = 0, qry, ack, cap, ocs, pen, lat;
    logic [7:0] map;
    dcp_reg_wr_t wr = '0;
    int n_mismatch = 0, comparisons = 0;
    always #20 clk = ~clk;
    dcp_dev_model dev (.ask_in(ask), .fault_in(flt), .query_out(qry), .ocs_low_out(ocs));
    dcp_charge_port_power uut (.SYS_CLK_IN(clk), .RST_B_IN(rst_b), .REG_WR_IN(wr), .CONFIG_DONE_IN(done),
        .CHARGE_PORT_ENABLE_MAP_OUT(map), .HUB_PORT_POWER_FEATURE_IN(feat), .HUB_PORT_POWER_ENABLE_IN(hen),
        .CHARGE_QUERY_IN(qry), .CHARGE_ACK_OUT(ack), .CHARGE_CAPABLE_OUT(cap),
        .OVERCURRENT_SENSE_LOW_IN(ocs), .PORT_POWER_ENABLE_OUT(pen), .OVERCURRENT_LATCHED_OUT(lat));
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        wr = '{1'b1, a, d};
        cyc(1);
        wr = '0;
        cyc(1);
    endtask
    task chk(input string s, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", s, e, g);
        end
    endtask
    task close_out;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        cyc(12);
        rst_b = 1;
        chk("pen", 8'h00, 8'(pen));
        wr_reg(8'hd0, 8'h0a);
        wr_reg(8'h55, 8'hff);
        chk("map", 8'h0a, map);
        ask = 3'h7;
        cyc(2);
        chk("ack", 8'h00, 8'(ack));
        done = 1;
        cyc(5);
        chk("pen", 8'h05, 8'(pen));
        chk("cap", 8'h05, 8'(cap));
        chk("ack", 8'h05, 8'(ack));
        wr_reg(8'hd0, 8'h0e);
        chk("map", 8'h0a, map);
        flt = 3'h1;
        cyc(2);
        chk("lat", 8'h01, 8'(lat));
        flt = 0;
        cyc(3);
        chk("pen", 8'h04, 8'(pen));
        feat = 3'h7;
        hen = 3'h3;
        cyc(3);
        chk("pen", 8'h03, 8'(pen));
        flt = 3'h2;
        cyc(2);
        chk("pen", 8'h01, 8'(pen));
        feat = 0;
        flt = 0;
        cyc(3);
        chk("pen", 8'h04, 8'(pen));
        chk("lat", 8'h01, 8'(lat));
        rst_b = 0;
        done = 0;
        ask = 0;
        cyc(2);
        chk("map", 8'h00, map);
        chk("lat", 8'h00, 8'(lat));
        rst_b = 1;
        cyc(2);
        chk("pen", 8'h00, 8'(pen));
        chk("cap", 8'h00, 8'(cap));
        close_out();
    end
endmodule
`default_nettype wire
